// ---- verilog/cte_exec.sv ----
// Contract
// - trap stacks PC, X, A, flags, vectors, 9 cycles
// - zero test sets N Z, clears V
// - zero test forms and their cycle counts
// - halt instruction clears interrupt mask only
// - halted core clock stopped until interrupt
// - stack modes add 8/16-bit offset to SP
// - indexed offsets; 16-bit offset high byte first
// - post-increment index after operand access
// - extended address high byte then low
// - four memory-to-memory move forms
// - compare-branch: direct address then branch offset
`timescale 1ns/1ps
`default_nettype none
module cte_exec #(
  parameter logic [15:0] RESET_PC = cte_pkg::PC_RST,
  parameter logic [15:0] TRAP_VEC = cte_pkg::TRAP_VEC,
  parameter logic [15:0] IRQ_VEC  = cte_pkg::IRQ_VEC
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // cpu memory bus, read data returned in the same cycle
  output logic [15:0]      mem_addr_o,
  output logic [7:0]       mem_wdata_o,
  output logic             mem_we_o,
  output logic             mem_re_o,
  input  wire logic [7:0]  mem_rdata_i,
  // interrupt pin and core clock gate
  input  wire logic        irq_i,
  output logic             core_clk_en_o
);
  typedef enum logic [2:0] {
    ST_FETCH, ST_PREFIX, ST_OPND, ST_EXEC, ST_PUSH, ST_VEC, ST_PAD, ST_WAIT
  } cte_state_e;

  cte_state_e          st_q, st_d;
  logic [7:0]          a_q, a_d, x_q, x_d, h_q, h_d, cc_q, cc_d;
  logic [15:0]         sp_q, sp_d, pc_q, pc_d;
  cte_pkg::cte_class_e cls_q, cls_d;
  cte_pkg::cte_mode_e  mode_q, mode_d;
  logic [7:0]          b1_q, b1_d, b2_q, b2_d, tmp_q, tmp_d;
  logic [1:0]          nb_q, nb_d, bidx_q, bidx_d;
  logic [2:0]          step_q, step_d;
  logic [3:0]          cyc_q, cyc_d, tgt_q, tgt_d;
  logic                virq_q, virq_d;
  logic                run_q, run_d;
  logic [2:0]          irq_sync_q, irq_sync_d;
  logic                irq_q, irq_d;
  logic [31:0]         rd_q, rd_d;

  cte_pkg::cte_dec_s   dec;
  logic [15:0]         hx, ea, vec;
  logic [7:0]          rr;
  logic                launch, done;

  function automatic logic [7:0] nzv(input logic [7:0] c, input logic [7:0] v);
    logic [7:0] r;
    r = c;
    r[cte_pkg::CC_V] = 1'b0;
    r[cte_pkg::CC_N] = v[7];
    r[cte_pkg::CC_Z] = (v == 8'h00);
    return r;
  endfunction

  assign hx  = {h_q, x_q};
  assign rr  = (nb_q == 2'h1) ? b1_q : b2_q;
  assign vec = virq_q ? IRQ_VEC : TRAP_VEC;

  // effective address of the operand (source operand for moves)
  always_comb begin
    ea = hx;
    case (mode_q)
      cte_pkg::MD_DIR, cte_pkg::MD_DD, cte_pkg::MD_DIXP: ea = {8'h00, b1_q};
      cte_pkg::MD_EXT:  ea = {b1_q, b2_q};
      cte_pkg::MD_IX1, cte_pkg::MD_IX1P: ea = hx + {8'h00, b1_q};
      cte_pkg::MD_IX2:  ea = hx + {b1_q, b2_q};
      cte_pkg::MD_SP1:  ea = sp_q + {8'h00, b1_q};
      cte_pkg::MD_SP2:  ea = sp_q + {b1_q, b2_q};
      default:          ea = hx;
    endcase
  end

  always_comb begin
    st_d = st_q;
    a_d = a_q;
    x_d = x_q;
    h_d = h_q;
    cc_d = cc_q;
    sp_d = sp_q;
    pc_d = pc_q;
    cls_d = cls_q;
    mode_d = mode_q;
    b1_d = b1_q;
    b2_d = b2_q;
    tmp_d = tmp_q;
    nb_d = nb_q;
    bidx_d = bidx_q;
    step_d = step_q;
    cyc_d = cyc_q + 4'h1;
    tgt_d = tgt_q;
    virq_d = virq_q;
    mem_addr_o = pc_q;
    mem_wdata_o = 8'h00;
    mem_we_o = 1'b0;
    mem_re_o = 1'b0;
    launch = 1'b0;
    done = 1'b0;
    dec = cte_pkg::decode(st_q == ST_PREFIX, mem_rdata_i);
    case (st_q)
      ST_FETCH: begin
        cyc_d = 4'h1;
        if (!run_q) begin
          cyc_d = cyc_q;
        end else if (irq_q && !cc_q[cte_pkg::CC_I]) begin
          virq_d = 1'b1;
          tgt_d = cte_pkg::CYC_TRAP;
          step_d = 3'h0;
          st_d = ST_PUSH;
        end else begin
          mem_re_o = 1'b1;
          pc_d = pc_q + 16'h0001;
          if (mem_rdata_i == cte_pkg::OP_PREFIX) begin
            st_d = ST_PREFIX;
          end else begin
            launch = 1'b1;
          end
        end
      end
      ST_PREFIX: begin
        mem_re_o = 1'b1;
        pc_d = pc_q + 16'h0001;
        launch = 1'b1;
      end
      ST_OPND: begin
        mem_re_o = 1'b1;
        pc_d = pc_q + 16'h0001;
        if (bidx_q == 2'h0) begin
          b1_d = mem_rdata_i;
        end else begin
          b2_d = mem_rdata_i;
        end
        bidx_d = bidx_q + 2'h1;
        if (bidx_q + 2'h1 == nb_q) begin
          st_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        step_d = step_q + 3'h1;
        mem_addr_o = ea;
        case (cls_q)
          cte_pkg::CL_TSTM: begin
            mem_re_o = 1'b1;
            cc_d = nzv(cc_q, mem_rdata_i);
            done = 1'b1;
          end
          cte_pkg::CL_STA: begin
            mem_we_o = 1'b1;
            mem_wdata_o = a_q;
            cc_d = nzv(cc_q, a_q);
            done = 1'b1;
          end
          cte_pkg::CL_CBEQ: begin
            mem_re_o = 1'b1;
            if (mem_rdata_i == a_q) begin
              pc_d = pc_q + {{8{rr[7]}}, rr};
            end
            if (mode_q == cte_pkg::MD_IXP || mode_q == cte_pkg::MD_IX1P) begin
              {h_d, x_d} = hx + 16'h0001;
            end
            done = 1'b1;
          end
          cte_pkg::CL_MOV: begin
            if (mode_q == cte_pkg::MD_IMD) begin
              mem_addr_o = {8'h00, b2_q};
              mem_we_o = 1'b1;
              mem_wdata_o = b1_q;
              cc_d = nzv(cc_q, b1_q);
              done = 1'b1;
            end else if (step_q == 3'h0) begin
              mem_re_o = 1'b1;
              tmp_d = mem_rdata_i;
            end else begin
              mem_we_o = 1'b1;
              mem_wdata_o = tmp_q;
              cc_d = nzv(cc_q, tmp_q);
              done = 1'b1;
              case (mode_q)
                cte_pkg::MD_DD:   mem_addr_o = {8'h00, b2_q};
                cte_pkg::MD_IXPD: mem_addr_o = {8'h00, b1_q};
                default:          mem_addr_o = hx;
              endcase
              if (mode_q != cte_pkg::MD_DD) begin
                {h_d, x_d} = hx + 16'h0001;
              end
            end
          end
          default: done = 1'b1;
        endcase
        if (done) begin
          st_d = (cyc_d >= tgt_q) ? ST_FETCH : ST_PAD;
        end
      end
      ST_PUSH: begin
        mem_we_o = 1'b1;
        mem_addr_o = sp_q;
        sp_d = sp_q - 16'h0001;
        step_d = step_q + 3'h1;
        case (step_q)
          3'h0:    mem_wdata_o = pc_q[7:0];
          3'h1:    mem_wdata_o = pc_q[15:8];
          3'h2:    mem_wdata_o = x_q;
          3'h3:    mem_wdata_o = a_q;
          default: mem_wdata_o = cc_q;
        endcase
        if (step_q == cte_pkg::PUSH_LAST) begin
          cc_d[cte_pkg::CC_I] = 1'b1;
          step_d = 3'h0;
          st_d = ST_VEC;
        end
      end
      ST_VEC: begin
        mem_re_o = 1'b1;
        step_d = step_q + 3'h1;
        if (step_q == 3'h0) begin
          mem_addr_o = vec;
          pc_d[15:8] = mem_rdata_i;
        end else begin
          mem_addr_o = vec + 16'h0001;
          pc_d[7:0] = mem_rdata_i;
          st_d = (cyc_d >= tgt_q) ? ST_FETCH : ST_PAD;
        end
      end
      ST_PAD: begin
        if (cyc_d >= tgt_q) begin
          st_d = ST_FETCH;
        end
      end
      ST_WAIT: begin
        cyc_d = cyc_q;
        if (irq_q) begin
          st_d = ST_FETCH;
        end
      end
      default: st_d = ST_FETCH;
    endcase
    if (launch) begin
      cls_d = dec.cls;
      mode_d = dec.mode;
      tgt_d = dec.cyc;
      nb_d = cte_pkg::operand_bytes(dec.mode, dec.cls);
      bidx_d = 2'h0;
      step_d = 3'h0;
      virq_d = 1'b0;
      st_d = (cyc_d >= dec.cyc) ? ST_FETCH : ST_PAD;
      case (dec.cls)
        cte_pkg::CL_TAP:  cc_d = a_q | cte_pkg::CC_ONES;
        cte_pkg::CL_TAX:  x_d = a_q;
        cte_pkg::CL_TPA:  a_d = cc_q;
        cte_pkg::CL_TXA:  a_d = x_q;
        cte_pkg::CL_TSX:  {h_d, x_d} = sp_q + 16'h0001;
        cte_pkg::CL_TXS:  sp_d = hx - 16'h0001;
        cte_pkg::CL_TSTA: cc_d = nzv(cc_q, a_q);
        cte_pkg::CL_TSTX: cc_d = nzv(cc_q, x_q);
        cte_pkg::CL_TRAP: st_d = ST_PUSH;
        cte_pkg::CL_WAIT: begin
          cc_d[cte_pkg::CC_I] = 1'b0;
          st_d = ST_WAIT;
        end
        default: ;
      endcase
      if (nb_d != 2'h0) begin
        st_d = ST_OPND;
      end else if (dec.cls == cte_pkg::CL_TSTM || dec.cls == cte_pkg::CL_STA ||
                   dec.cls == cte_pkg::CL_CBEQ || dec.cls == cte_pkg::CL_MOV) begin
        st_d = ST_EXEC;
      end
    end
  end

  // the gate is an output only; the sequencer runs on to ST_FETCH and holds there while run is clear
  assign core_clk_en_o = run_q && (st_q != ST_WAIT);

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st_q <= ST_FETCH;
      a_q <= 8'h00;
      x_q <= 8'h00;
      h_q <= 8'h00;
      cc_q <= cte_pkg::CC_RST;
      sp_q <= cte_pkg::SP_RST;
      pc_q <= RESET_PC;
      cls_q <= cte_pkg::CL_NOP;
      mode_q <= cte_pkg::MD_INH;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      tmp_q <= 8'h00;
      nb_q <= 2'h0;
      bidx_q <= 2'h0;
      step_q <= 3'h0;
      cyc_q <= 4'h0;
      tgt_q <= 4'h1;
      virq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      a_q <= a_d;
      x_q <= x_d;
      h_q <= h_d;
      cc_q <= cc_d;
      sp_q <= sp_d;
      pc_q <= pc_d;
      cls_q <= cls_d;
      mode_q <= mode_d;
      b1_q <= b1_d;
      b2_q <= b2_d;
      tmp_q <= tmp_d;
      nb_q <= nb_d;
      bidx_q <= bidx_d;
      step_q <= step_d;
      cyc_q <= cyc_d;
      tgt_q <= tgt_d;
      virq_q <= virq_d;
    end
  end

  // interrupt pin: a level change counts once the last two stages agree
  always_comb begin
    irq_sync_d = {irq_sync_q[1:0], irq_i};
    irq_d = (irq_sync_q[2] == irq_sync_q[1]) ? irq_sync_q[2] : irq_q;
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      irq_sync_q <= 3'h0;
      irq_q <= 1'b0;
    end else begin
      irq_sync_q <= irq_sync_d;
      irq_q <= irq_d;
    end
  end

  // apb: read data captured in setup, answered in the first access cycle
  logic apb_setup, apb_access, apb_hit;
  assign apb_setup  = psel_i && !penable_i;
  assign apb_access = psel_i && penable_i;
  assign apb_hit    = (paddr_i == cte_pkg::OFS_CTRL) || (paddr_i == cte_pkg::OFS_STATUS) ||
                      (paddr_i == cte_pkg::OFS_REGS) || (paddr_i == cte_pkg::OFS_SPPC) ||
                      (paddr_i == cte_pkg::OFS_FLAGS);
  assign pready_o   = apb_access;
  assign pslverr_o  = apb_access && !apb_hit;
  assign prdata_o   = rd_q;

  always_comb begin
    run_d = run_q;
    rd_d = rd_q;
    if (apb_access && pwrite_i && paddr_i == cte_pkg::OFS_CTRL) begin
      run_d = pwdata_i[cte_pkg::CTRL_RUN];
    end
    if (apb_setup && !pwrite_i) begin
      rd_d = 32'h0000_0000;
      case (paddr_i)
        cte_pkg::OFS_CTRL:   rd_d[cte_pkg::CTRL_RUN] = run_q;
        cte_pkg::OFS_STATUS: begin
          rd_d[cte_pkg::STAT_WAIT] = (st_q == ST_WAIT);
          rd_d[cte_pkg::STAT_RUN] = core_clk_en_o;
        end
        cte_pkg::OFS_REGS:   rd_d = {8'h00, h_q, x_q, a_q};
        cte_pkg::OFS_SPPC:   rd_d = {sp_q, pc_q};
        cte_pkg::OFS_FLAGS:  rd_d = {24'h00_0000, cc_q};
        default:             rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      run_q <= cte_pkg::CTRL_RUN_RST;
      rd_q <= 32'h0000_0000;
    end else begin
      run_q <= run_d;
      rd_q <= rd_d;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/cte_pkg.sv ----
`default_nettype none
package cte_pkg;
  // register map (byte addresses, one 32-bit word each)
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h04;
  localparam logic [7:0]  OFS_REGS   = 8'h08;
  localparam logic [7:0]  OFS_SPPC   = 8'h0c;
  localparam logic [7:0]  OFS_FLAGS  = 8'h10;
  localparam int          CTRL_RUN   = 0;
  localparam int          STAT_WAIT  = 0;
  localparam int          STAT_RUN   = 1;
  localparam logic        CTRL_RUN_RST = 1'b1;
  // condition_flags layout
  localparam int          CC_V = 7;
  localparam int          CC_H = 4;
  localparam int          CC_I = 3;
  localparam int          CC_N = 2;
  localparam int          CC_Z = 1;
  localparam int          CC_C = 0;
  localparam logic [7:0]  CC_ONES   = 8'h60;
  localparam logic [7:0]  CC_RST    = 8'h68;
  localparam logic [15:0] SP_RST    = 16'h00ff;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [15:0] TRAP_VEC  = 16'hfffc;
  localparam logic [15:0] IRQ_VEC   = 16'hfffa;
  localparam logic [7:0]  OP_PREFIX = 8'h9e;
  localparam logic [3:0]  CYC_TRAP  = 4'h9;
  localparam logic [2:0]  PUSH_LAST = 3'h4;

  typedef enum logic [3:0] {
    MD_INH, MD_DIR, MD_EXT, MD_IX, MD_IX1, MD_IX2, MD_SP1, MD_SP2,
    MD_IXP, MD_IX1P, MD_DD, MD_IMD, MD_IXPD, MD_DIXP
  } cte_mode_e;

  typedef enum logic [3:0] {
    CL_NOP, CL_TRAP, CL_WAIT, CL_TAP, CL_TAX, CL_TPA, CL_TSTA, CL_TSTX,
    CL_TSX, CL_TXA, CL_TXS, CL_TSTM, CL_STA, CL_MOV, CL_CBEQ
  } cte_class_e;

  typedef struct packed {
    cte_class_e cls;
    cte_mode_e  mode;
    logic [3:0] cyc;
  } cte_dec_s;

  // unknown opcodes belong to other units; here they retire as no-ops in one cycle, or in two after the prefix byte
  function automatic cte_dec_s decode(input logic pre, input logic [7:0] op);
    cte_dec_s d;
    d = '{CL_NOP, MD_INH, 4'h1};
    case ({pre, op})
      9'h083:  d = '{CL_TRAP, MD_INH, CYC_TRAP};
      9'h084:  d = '{CL_TAP,  MD_INH, 4'h2};
      9'h097:  d = '{CL_TAX,  MD_INH, 4'h1};
      9'h085:  d = '{CL_TPA,  MD_INH, 4'h1};
      9'h03d:  d = '{CL_TSTM, MD_DIR, 4'h3};
      9'h04d:  d = '{CL_TSTA, MD_INH, 4'h1};
      9'h05d:  d = '{CL_TSTX, MD_INH, 4'h1};
      9'h06d:  d = '{CL_TSTM, MD_IX1, 4'h3};
      9'h07d:  d = '{CL_TSTM, MD_IX,  4'h2};
      9'h16d:  d = '{CL_TSTM, MD_SP1, 4'h4};
      9'h095:  d = '{CL_TSX,  MD_INH, 4'h2};
      9'h09f:  d = '{CL_TXA,  MD_INH, 4'h1};
      9'h094:  d = '{CL_TXS,  MD_INH, 4'h2};
      9'h08f:  d = '{CL_WAIT, MD_INH, 4'h1};
      9'h0b7:  d = '{CL_STA,  MD_DIR, 4'h3};
      9'h0c7:  d = '{CL_STA,  MD_EXT, 4'h4};
      9'h0d7:  d = '{CL_STA,  MD_IX2, 4'h4};
      9'h0e7:  d = '{CL_STA,  MD_IX1, 4'h3};
      9'h0f7:  d = '{CL_STA,  MD_IX,  4'h2};
      9'h1e7:  d = '{CL_STA,  MD_SP1, 4'h4};
      9'h1d7:  d = '{CL_STA,  MD_SP2, 4'h5};
      9'h04e:  d = '{CL_MOV,  MD_DD,   4'h5};
      9'h05e:  d = '{CL_MOV,  MD_DIXP, 4'h4};
      9'h06e:  d = '{CL_MOV,  MD_IMD,  4'h4};
      9'h07e:  d = '{CL_MOV,  MD_IXPD, 4'h4};
      9'h031:  d = '{CL_CBEQ, MD_DIR,  4'h5};
      9'h061:  d = '{CL_CBEQ, MD_IX1P, 4'h5};
      9'h071:  d = '{CL_CBEQ, MD_IXP,  4'h4};
      9'h161:  d = '{CL_CBEQ, MD_SP1,  4'h6};
      default: d = '{CL_NOP, MD_INH, 4'h1};
    endcase
    return d;
  endfunction

  // bytes after the opcode; compare-and-branch adds its offset byte last
  function automatic logic [1:0] operand_bytes(input cte_mode_e m, input cte_class_e c);
    logic [1:0] n;
    n = 2'h0;
    case (m)
      MD_DIR, MD_IX1, MD_SP1, MD_IX1P, MD_IXPD, MD_DIXP: n = 2'h1;
      MD_EXT, MD_IX2, MD_SP2, MD_DD, MD_IMD:             n = 2'h2;
      default:                                           n = 2'h0;
    endcase
    if (c == CL_CBEQ) begin
      n = n + 2'h1;
    end
    return n;
  endfunction
endpackage
`default_nettype wire

// ---- tb/cte_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module cte_checker #(
  parameter logic [15:0] TRAP_VEC = cte_pkg::TRAP_VEC
) (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        reset_n_i,
  // apb
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // cpu bus
  input wire logic [15:0] mem_addr_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic        mem_we_o,
  input wire logic        mem_re_o,
  input wire logic [7:0]  mem_rdata_i,
  // interrupt and clock gate
  input wire logic        irq_i,
  input wire logic        core_clk_en_o
);
  // operand bytes are kept off these opcode values, so a match marks a fetch
  logic op_rd;
  assign op_rd = mem_re_o && core_clk_en_o;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  apb_ready_a: assert property (pready_o == (psel_i && penable_i))
    else $error("pready wrong");
  apb_err_a: assert property (psel_i && penable_i |->
    pslverr_o == !(paddr_i inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}))
    else $error("pslverr wrong");
  trap_seq_a: assert property (op_rd && mem_rdata_i == 8'h83 |=> mem_we_o [*5]
    ##1 (mem_re_o && mem_addr_o == TRAP_VEC)
    ##1 (mem_re_o && mem_addr_o == TRAP_VEC + 16'h1) ##2 mem_re_o)
    else $error("trap sequence wrong");
  trap_pc_a: assert property (op_rd && mem_rdata_i == 8'h83 |-> ##2
    {mem_wdata_o, $past(mem_wdata_o)} == $past(mem_addr_o, 2) + 16'h1)
    else $error("stacked pc wrong");
  stack_down_a: assert property (op_rd && mem_rdata_i == 8'h83 |->
    ##2 mem_addr_o == $past(mem_addr_o) - 16'h1 ##1 mem_addr_o == $past(mem_addr_o) - 16'h1)
    else $error("stack order wrong");
  wait_off_a: assert property (op_rd && mem_rdata_i == 8'h8f |=> !core_clk_en_o [*3])
    else $error("core clock not stopped");
  irq_wake_a: assert property (irq_i [*8] |-> core_clk_en_o)
    else $error("core clock not resumed");
  tst_dir_a: assert property (op_rd && mem_rdata_i == 8'h3d ##1 mem_re_o |->
    ##1 (mem_re_o && mem_addr_o == {8'h00, $past(mem_rdata_i)}) ##1 mem_re_o)
    else $error("direct test wrong");
  tst_inh_a: assert property (op_rd && (mem_rdata_i == 8'h4d || mem_rdata_i == 8'h5d)
    |=> mem_re_o && mem_addr_o == $past(mem_addr_o) + 16'h1)
    else $error("inherent test not one cycle");
  ext_addr_a: assert property (op_rd && mem_rdata_i == 8'hc7 |-> ##3 (mem_we_o &&
    mem_addr_o == {$past(mem_rdata_i, 2), $past(mem_rdata_i)}))
    else $error("extended address wrong");
endmodule
bind cte_exec cte_checker #(.TRAP_VEC(TRAP_VEC)) u_cte_checker (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .mem_re_o(mem_re_o),
  .mem_rdata_i(mem_rdata_i), .irq_i(irq_i), .core_clk_en_o(core_clk_en_o)
);
`default_nettype wire

// ---- tb/cte_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cte_mem_model (
  // cpu bus
  input  wire logic        mclk_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic [7:0]  mem_wdata_i,
  input  wire logic        mem_we_i,
  input  wire logic        mem_re_i,
  output logic [7:0]       mem_rdata_o
);
  logic [7:0] mem [0:65535];
  // an idle read port shows the inverse so stale data never looks valid
  assign mem_rdata_o = mem_re_i ? mem[mem_addr_i] : ~mem[mem_addr_i];
  // plain always: the bench also preloads this array
  always @(posedge mclk_i) begin
    if (mem_we_i) begin
      mem[mem_addr_i] <= mem_wdata_i;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tb_cte_exec.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_cte_exec;
  typedef struct packed {
    logic [31:0] prog;
    logic [7:0]  ofs;
    logic [31:0] msk;
    logic [31:0] exp;
  } cte_row_s;
  localparam cte_row_s ROWS [18] = '{
    '{32'h4d000000, 8'h10, 32'hffffffff, 32'h0000006a},
    '{32'h854d0000, 8'h10, 32'hffffffff, 32'h00000068},
    '{32'h85975d00, 8'h08, 32'hffffffff, 32'h00006868},
    '{32'h3d400000, 8'h10, 32'hffffffff, 32'h0000006c},
    '{32'h3d408500, 8'h08, 32'hffffffff, 32'h0000006c},
    '{32'h957d0000, 8'h10, 32'hffffffff, 32'h0000006c},
    '{32'h6d050000, 8'h10, 32'hffffffff, 32'h0000006a},
    '{32'h9e6d0100, 8'h10, 32'hffffffff, 32'h0000006c},
    '{32'h95859794, 8'h0c, 32'hffff0000, 32'h01670000},
    '{32'h95859f00, 8'h08, 32'hffffffff, 32'h00010000},
    '{32'hc7000385, 8'h08, 32'hffffffff, 32'h00000000},
    '{32'h84000000, 8'h10, 32'hffffffff, 32'h00000060},
    '{32'h4e403000, 8'h10, 32'hffffffff, 32'h0000006c},
    '{32'h6e803000, 8'h10, 32'hffffffff, 32'h0000006c},
    '{32'h957e3000, 8'h08, 32'hffffffff, 32'h00010100},
    '{32'h5e400000, 8'h08, 32'hffffffff, 32'h00000100},
    '{32'h31050185, 8'h08, 32'hffffffff, 32'h00000000},
    '{32'h71018500, 8'h08, 32'hffffffff, 32'h00000168}
  };
  localparam logic [7:0] STK [10] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h68,
                                      8'h41, 8'h00, 8'h00, 8'h00, 8'h60};
  logic        mclk    = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        irq     = 1'b0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic        pready, pslverr, mem_we, mem_re, core_clk_en, er;
  int          err_total   = 0;
  int          comparisons = 0;

  always #2.5 mclk = ~mclk;

  cte_exec u_cte_exec (
    .mclk_i(mclk), .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .mem_we_o(mem_we), .mem_re_o(mem_re),
    .mem_rdata_i(mem_rdata), .irq_i(irq), .core_clk_en_o(core_clk_en)
  );
  cte_mem_model u_cte_mem_model (
    .mclk_i(mclk), .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata),
    .mem_we_i(mem_we), .mem_re_i(mem_re), .mem_rdata_o(mem_rdata)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic restart();
    reset_n <= 1'b0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
  endtask

  // one apb transfer; an idle edge follows so the next setup never collides
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge mclk);
    end
    if (n == 50) begin
      err_total++;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    conclude();
  end

  initial begin
    for (int i = 0; i < 65536; i++) begin
      u_cte_mem_model.mem[i] = 8'h00;
    end
    u_cte_mem_model.mem[16'h0040] = 8'h80;
    u_cte_mem_model.mem[16'h0100] = 8'h80;
    foreach (ROWS[i]) begin
      for (int b = 0; b < 4; b++) begin
        u_cte_mem_model.mem[b] = ROWS[i].prog[31 - 8 * b -: 8];
      end
      restart();
      repeat (30) @(posedge mclk);
      // stopping the core freezes its registers before they are read
      apb(1'b1, cte_pkg::OFS_CTRL, 32'h0);
      apb(1'b0, ROWS[i].ofs, 32'h0);
      check(rd & ROWS[i].msk, ROWS[i].exp);
    end
    for (int b = 0; b < 4; b++) begin
      u_cte_mem_model.mem[b] = (b == 0) ? 8'h83 : 8'h00;
    end
    u_cte_mem_model.mem[16'hfffd] = 8'h40;
    u_cte_mem_model.mem[16'h0040] = 8'h8f;
    u_cte_mem_model.mem[16'hfffb] = 8'h50;
    restart();
    apb(1'b0, cte_pkg::OFS_CTRL, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, er}, 32'h1);
    repeat (30) @(posedge mclk);
    apb(1'b0, cte_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, cte_pkg::OFS_FLAGS, 32'h0);
    check(rd, 32'h60);
    check({31'h0, core_clk_en}, 32'h0);
    irq <= 1'b1;
    repeat (40) @(posedge mclk);
    irq <= 1'b0;
    check({31'h0, core_clk_en}, 32'h1);
    for (int i = 0; i < 10; i++) begin
      check({24'h0, u_cte_mem_model.mem[16'h00ff - i]}, {24'h0, STK[i]});
    end
    apb(1'b0, cte_pkg::OFS_SPPC, 32'h0);
    check(rd & 32'hffff0000, 32'h00f50000);
    conclude();
  end
endmodule
`default_nettype wire
